/* inc/backplane_defs.svh */
// constants shared by both ends of the backplane interrupt and reset logic
// assumes a 40 MHz board clock on each end
`ifndef BACKPLANE_DEFS_SVH
`define BACKPLANE_DEFS_SVH

`define IRQ_LINES 7
`define RESV_LINES 3
`define RESV_RELEASE 3'h7

// board clock and timing
`define CLK_PERIOD_NS 25
`define SYSRST_HOLD_NS 10000
`define SYSRST_HOLD_CYC ((`SYSRST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W 9
`define BUS_TIMEOUT_NS 20000
`define BUS_TIMEOUT_CYC (`BUS_TIMEOUT_NS / `CLK_PERIOD_NS)
`define TMO_CNT_W 10

// backplane slot window: address bits 23:20 base, 19:16 slot
`define SLOT_BASE 4'h6
`define STATUS_OFS 16'hfffc
`define CONFIG_OFS 16'hfffe

// local slave addresses
`define MAILBOX_ADDR 24'h4e0004
`define SLAVE_FLAG_ADDR 24'h4e0006

// configuration word fields
`define CFG_RESET_BIT 15
`define CFG_HALT_BIT 14
`define CFG_INT_BIT 13
`define CFG_PRI_LSB 11
`define CFG_LVL_LSB 8
`define CFG_RESET_VAL 16'hc000

// status word fields
`define ST_SI_BIT 15
`define ST_MI_BIT 14
`define ST_SLAVE_BIT 8

// interrupt levels
`define LVL_POWER 3'h7
`define LVL_TIMER 3'h6
`define LVL_MEMCTL 3'h5
`define LVL_SERIAL 3'h4
`define LVL_SLAVE_MAX 3'h4

`endif

/* inc/backplane_pkg.sv */
// types shared by both ends of the backplane interrupt and reset logic
// assumes backplane_defs.svh holds the numbers
package backplane_pkg;

  typedef enum logic [1:0] {
    SZ_LONG = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10,
    SZ_TRIPLE = 2'b11
  } xfer_size_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_RECOVER = 2'b10
  } bus_state_type;

  typedef enum logic [0:0] {
    SL_IDLE = 1'b0,
    SL_ACK = 1'b1
  } slave_state_type;

  // active-high {upper, lower} byte strobes on a 16-bit port
  function automatic logic [1:0] byte_strobes(input xfer_size_type size,
                                              input logic a0);
    if (size == SZ_BYTE) begin
      byte_strobes = a0 ? 2'h1 : 2'h2;
    end else begin
      byte_strobes = a0 ? 2'h1 : 2'h3;
    end
  endfunction : byte_strobes

endpackage : backplane_pkg

/* inc/backplane_if.sv */
// backplane wires between the master board and one non-master board
// each end drives only enables and values; the wire levels are resolved here
`timescale 1ns/1ps
interface backplane_if;
  // master drives
  logic [23:1] addrBus;
  logic [15:0] masterData;
  logic masterDataOeN;
  logic readNotWrite;
  logic addressStrobeN;
  logic upperByteStrobeOut;
  logic lowerByteStrobeOut;
  logic systemResetOeN;
  logic [2:0] masterResvOeN;
  // non-master board drives
  logic [7:1] irqOeN;
  logic busErrorOeN;
  logic dtackOeN;
  logic [15:0] slaveData;
  logic slaveDataOeN;
  logic [2:0] slaveResvOeN;
  // resolved wire levels; open-collector lines pull high when released
  logic [7:1] backplaneIrqN;
  logic backplaneBusErrorN;
  logic systemResetN;
  logic upperByteStrobeN;
  logic lowerByteStrobeN;
  logic dtackN;
  logic [15:0] dataBus;
  logic [2:0] reservedFloating;

  assign backplaneIrqN = irqOeN;
  assign backplaneBusErrorN = busErrorOeN;
  assign systemResetN = systemResetOeN;
  assign upperByteStrobeN = upperByteStrobeOut;
  assign lowerByteStrobeN = lowerByteStrobeOut;
  assign dtackN = dtackOeN;
  assign dataBus = !masterDataOeN ? masterData :
                   (!slaveDataOeN ? slaveData : 16'hffff);
  assign reservedFloating = masterResvOeN & slaveResvOeN;

  modport master (
    output addrBus, masterData, masterDataOeN, readNotWrite,
    output addressStrobeN, upperByteStrobeOut, lowerByteStrobeOut,
    output systemResetOeN, masterResvOeN,
    input backplaneIrqN, backplaneBusErrorN, dtackN, dataBus
  );

  modport slave (
    output irqOeN, busErrorOeN, dtackOeN, slaveData, slaveDataOeN,
    output slaveResvOeN,
    input addrBus, readNotWrite, addressStrobeN, upperByteStrobeN,
    input lowerByteStrobeN, systemResetN, dataBus
  );
endinterface : backplane_if

/* hdl/master_irq_end.sv */
// master board end: interrupt priority, system reset, bus cycles
// assumes one backplane_if toward the other boards and a 40 MHz clk
`timescale 1ns/1ps
`include "backplane_defs.svh"

module master_irq_end
  import backplane_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // on-board interrupt sources, asynchronous
  input wire logic powerFailN,
  input wire logic timerIrq,
  input wire logic serialIrq,
  // processor side
  input wire logic resetInstr,
  input wire logic cpuReq,
  input wire logic cpuRead,
  input wire xfer_size_type cpuSize,
  input wire logic [23:0] cpuAddr,
  input wire logic [15:0] cpuWdata,
  output logic [2:0] ipl,
  output logic autovector,
  output logic cpuDone,
  output logic cpuBusError,
  output logic [15:0] cpuRdata,
  output logic coprocResetN,
  // backplane
  backplane_if.master bp
);

  typedef struct packed {
    logic [2:0] srcS1;
    logic [2:0] srcS2;
    logic [7:1] irqS1;
    logic [7:1] irqS2;
    logic dtackS1;
    logic dtackS2;
    logic berrS1;
    logic berrS2;
    logic [2:0] ipl;
    logic avec;
    bus_state_type bus;
    logic [23:1] addr;
    logic [15:0] wdata;
    logic dataOeN;
    logic rnw;
    logic asN;
    logic udsN;
    logic ldsN;
    logic [15:0] rdata;
    logic done;
    logic berr;
    logic [`TMO_CNT_W-1:0] tmo;
    logic [`RST_CNT_W-1:0] rstCnt;
    logic rstOeN;
    logic copN;
    logic [2:0] resvOeN;
  } m_state_type;

  m_state_type r;
  m_state_type n;
  logic [7:1] active;
  logic [1:0] strobes;

  always_comb begin
    n = r;
    active = '0;
    strobes = byte_strobes(cpuSize, cpuAddr[0]);
    n.done = 1'b0;
    n.berr = 1'b0;
    n.resvOeN = `RESV_RELEASE;

    // two-stage synchronisers for the on-board sources and the request, acknowledge and bus error lines; the data word is not synchronised
    n.srcS1 = {~powerFailN, timerIrq, serialIrq};
    n.srcS2 = r.srcS1;
    n.irqS1 = bp.backplaneIrqN;
    n.irqS2 = r.irqS1;
    n.dtackS1 = bp.dtackN;
    n.dtackS2 = r.dtackS1;
    n.berrS1 = bp.backplaneBusErrorN;
    n.berrS2 = r.berrS1;

    // level map: on-board sources share the table with the lines
    active = ~r.irqS2;
    active[`LVL_POWER] = r.srcS2[2];
    active[`LVL_TIMER] = r.srcS2[1];
    active[`LVL_SERIAL] = r.srcS2[0] | ~r.irqS2[`LVL_SERIAL];

    // no acknowledge cycle: the level simply follows the lines
    n.ipl = 3'h0;
    for (int i = 1; i <= `IRQ_LINES; i++) begin
      if (active[i]) begin
        n.ipl = 3'(i);
      end
    end
    n.avec = (n.ipl != 3'h0);

    // system reset stretch; the master itself keeps running
    if (resetInstr) begin
      n.rstCnt = `RST_CNT_W'(`SYSRST_HOLD_CYC);
    end else if (r.rstCnt != '0) begin
      n.rstCnt = r.rstCnt - `RST_CNT_W'(1);
    end
    n.rstOeN = (n.rstCnt == '0);
    n.copN = (n.rstCnt == '0);

    // backplane bus cycle
    case (r.bus)
      BUS_IDLE: begin
        // requests are refused while system reset is driven
        if (cpuReq && r.rstOeN) begin
          n.addr = cpuAddr[23:1];
          n.udsN = ~strobes[1];
          n.ldsN = ~strobes[0];
          n.rnw = cpuRead;
          n.wdata = cpuWdata;
          n.dataOeN = cpuRead;
          n.asN = 1'b0;
          n.tmo = '0;
          n.bus = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        n.tmo = r.tmo + `TMO_CNT_W'(1);
        if (!r.dtackS2) begin
          // data has stood for two cycles behind the acknowledge
          n.rdata = bp.dataBus;
          n.done = 1'b1;
          n.bus = BUS_RECOVER;
        end else if (!r.berrS2 ||
                     r.tmo == `TMO_CNT_W'(`BUS_TIMEOUT_CYC)) begin
          n.berr = 1'b1;
          n.bus = BUS_RECOVER;
        end
        if (n.bus == BUS_RECOVER) begin
          n.asN = 1'b1;
          n.udsN = 1'b1;
          n.ldsN = 1'b1;
          n.dataOeN = 1'b1;
        end
      end
      BUS_RECOVER: begin
        // wait for the slave to let go before the next cycle
        if (r.dtackS2 && r.berrS2) begin
          n.bus = BUS_IDLE;
        end
      end
      default: begin
        n.bus = BUS_IDLE;
      end
    endcase
  end

  // runs on the board clock only; the backplane clock pin is never read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.srcS1 <= 3'h0;
      r.srcS2 <= 3'h0;
      r.irqS1 <= 7'h7f;
      r.irqS2 <= 7'h7f;
      r.dtackS1 <= 1'b1;
      r.dtackS2 <= 1'b1;
      r.berrS1 <= 1'b1;
      r.berrS2 <= 1'b1;
      r.bus <= BUS_IDLE;
      r.dataOeN <= 1'b1;
      r.rnw <= 1'b1;
      r.asN <= 1'b1;
      r.udsN <= 1'b1;
      r.ldsN <= 1'b1;
      r.rstCnt <= `RST_CNT_W'(`SYSRST_HOLD_CYC);
      r.rstOeN <= 1'b0;
      r.copN <= 1'b0;
      r.resvOeN <= `RESV_RELEASE;
    end else begin
      r <= n;
    end
  end

  assign ipl = r.ipl;
  assign autovector = r.avec;
  assign cpuDone = r.done;
  assign cpuBusError = r.berr;
  assign cpuRdata = r.rdata;
  assign coprocResetN = r.copN;
  assign bp.addrBus = r.addr;
  assign bp.masterData = r.wdata;
  assign bp.masterDataOeN = r.dataOeN;
  assign bp.readNotWrite = r.rnw;
  assign bp.addressStrobeN = r.asN;
  assign bp.upperByteStrobeOut = r.udsN;
  assign bp.lowerByteStrobeOut = r.ldsN;
  assign bp.systemResetOeN = r.rstOeN;
  assign bp.masterResvOeN = r.resvOeN;

endmodule : master_irq_end

/* hdl/slave_board_end.sv */
// non-master board end: request flag, status/config port, bus error
// assumes one backplane_if toward the master and a 40 MHz clk
`timescale 1ns/1ps
`include "backplane_defs.svh"

module slave_board_end
  import backplane_pkg::*;
#(
  parameter bit IS_MEMCTL = 1'b0,
  parameter logic [4:0] BOARD_TYPE = 5'h0a // arbitrary value
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // board strap and fault
  input wire logic [3:0] slot,
  input wire logic fault,
  // local processor side
  input wire logic localRead,
  input wire logic localWrite,
  input wire logic [23:0] localAddr,
  input wire logic [7:0] localWdata,
  output logic [7:0] localRdata,
  output logic slaveIntr,
  output logic cpuResetN,
  output logic cpuHaltN,
  output logic [1:0] busPriority,
  output logic coprocResetN,
  // backplane
  backplane_if.slave bp
);

  typedef struct packed {
    logic asS1;
    logic asS2;
    logic rstS1;
    logic rstS2;
    slave_state_type st;
    logic [15:0] cfg;
    logic [7:0] status;
    logic si;
    logic mi;
    logic dtackOeN;
    logic berrOeN;
    logic dataOeN;
    logic [15:0] data;
    logic [7:1] irqOeN;
    logic [7:0] rdLocal;
    logic copN;
  } s_state_type;

  localparam s_state_type RESET_STATE = '{
    asS1: 1'b1, asS2: 1'b1, rstS1: 1'b0, rstS2: 1'b0, st: SL_IDLE,
    cfg: `CFG_RESET_VAL, status: 8'h00, si: 1'b0, mi: 1'b0,
    dtackOeN: 1'b1, berrOeN: 1'b1, dataOeN: 1'b1, data: 16'h0000,
    irqOeN: 7'h7f, rdLocal: 8'h00, copN: 1'b0};

  s_state_type r;
  s_state_type n;
  logic hit;
  logic [2:0] lvl;

  always_comb begin
    n = r;
    hit = bp.addrBus[23:20] == `SLOT_BASE && bp.addrBus[19:16] == slot;
    lvl = r.cfg[`CFG_LVL_LSB +: 3];
    n.asS1 = bp.addressStrobeN;
    n.asS2 = r.asS1;
    n.rstS1 = bp.systemResetN;
    n.rstS2 = r.rstS1;
    n.copN = r.cfg[`CFG_RESET_BIT];

    // local processor: mailbox read clears si, flag write raises mi
    if (localRead && localAddr == `MAILBOX_ADDR) begin
      n.rdLocal = r.cfg[7:0];
      n.si = 1'b0;
    end
    if (localWrite && localAddr == `MAILBOX_ADDR) begin
      n.status = localWdata;
    end

    case (r.st)
      SL_IDLE: begin
        // address lines are stable while the synced strobe is low
        if (!r.asS2 && hit) begin
          if (fault) begin
            n.berrOeN = 1'b0;
          end else if (bp.readNotWrite &&
                       bp.addrBus[15:1] == 15'(`STATUS_OFS >> 1)) begin
            n.data = {r.si, r.mi, BOARD_TYPE, 1'b1, r.status};
            n.dataOeN = 1'b0;
            n.dtackOeN = 1'b0;
            if (!bp.lowerByteStrobeN) begin
              n.mi = 1'b0;
            end
          end else if (!bp.readNotWrite &&
                       bp.addrBus[15:1] == 15'(`CONFIG_OFS >> 1)) begin
            if (!bp.upperByteStrobeN) begin
              n.cfg[15:8] = bp.dataBus[15:8];
              if (bp.dataBus[`CFG_INT_BIT]) begin
                n.si = 1'b1;
              end
            end
            if (!bp.lowerByteStrobeN) begin
              n.cfg[7:0] = bp.dataBus[7:0];
            end
            n.dtackOeN = 1'b0;
          end else begin
            n.dtackOeN = 1'b0;
          end
          n.st = SL_ACK;
        end
      end
      SL_ACK: begin
        if (r.asS2) begin
          n.dtackOeN = 1'b1;
          n.berrOeN = 1'b1;
          n.dataOeN = 1'b1;
          n.st = SL_IDLE;
        end
      end
      default: begin
        n.st = SL_IDLE;
      end
    endcase

    // set after the master's clear, so a same-cycle raise is kept
    if (localWrite && localAddr == `SLAVE_FLAG_ADDR) begin
      n.mi = 1'b1;
    end

    // level decoder onto the open-collector lines
    for (int i = 1; i <= `IRQ_LINES; i++) begin
      if (IS_MEMCTL) begin
        n.irqOeN[i] = !(n.mi && 3'(i) == `LVL_MEMCTL);
      end else begin
        n.irqOeN[i] = !(n.mi && 3'(i) == lvl &&
                        lvl <= `LVL_SLAVE_MAX);
      end
    end

    // system reset: whole board back to reset, lines released
    if (!r.rstS2) begin
      n = RESET_STATE;
      n.asS1 = bp.addressStrobeN;
      n.asS2 = r.asS1;
      n.rstS1 = bp.systemResetN;
      n.rstS2 = r.rstS1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= RESET_STATE;
    end else begin
      r <= n;
    end
  end

  assign localRdata = r.rdLocal;
  assign slaveIntr = r.si;
  assign cpuResetN = r.cfg[`CFG_RESET_BIT];
  assign cpuHaltN = r.cfg[`CFG_HALT_BIT];
  assign busPriority = r.cfg[`CFG_PRI_LSB +: 2];
  assign coprocResetN = r.copN;
  assign bp.irqOeN = r.irqOeN;
  assign bp.busErrorOeN = r.berrOeN;
  assign bp.dtackOeN = r.dtackOeN;
  assign bp.slaveData = r.data;
  assign bp.slaveDataOeN = r.dataOeN;
  assign bp.slaveResvOeN = `RESV_RELEASE;

endmodule : slave_board_end

/* tb/backplane_sva.sv */
// checker on the backplane wires between master end and slave end
// assumes one clock domain, clk, with sys_rst synchronous active high
`timescale 1ns/1ps
module backplane_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // backplane wires
  input wire logic addressStrobeN,
  input wire logic upperByteStrobeN,
  input wire logic lowerByteStrobeN,
  input wire logic readNotWrite,
  input wire logic masterDataOeN,
  input wire logic slaveDataOeN,
  input wire logic [7:1] irqOeN,
  input wire logic busErrorOeN,
  input wire logic dtackOeN,
  input wire logic systemResetN,
  input wire logic [2:0] reservedFloating
);
  // saturates so a stuck reset cannot wrap back into the legal window
  logic [9:0] lowCnt_r;
  always_ff @(posedge clk) begin
    if (sys_rst || systemResetN) begin
      lowCnt_r <= 10'h0;
    end else if (lowCnt_r != 10'h3ff) begin
      lowCnt_r <= lowCnt_r + 10'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RESV_IDLE: assert property (reservedFloating == 3'h7)
    else $error("reserved line driven");
  AST_ONE_LINE: assert property ($onehot0(~irqOeN))
    else $error("slave drives more than one request line");
  AST_SLAVE_LEVELS: assert property (irqOeN[7:6] == 2'h3)
    else $error("slave drives request level above five");
  AST_RST_RELEASE: assert property (!systemResetN [*4] |->
    irqOeN == 7'h7f && busErrorOeN && dtackOeN)
    else $error("slave lines driven during system reset");
  AST_STROBE_IDLE: assert property (addressStrobeN |->
    upperByteStrobeN && lowerByteStrobeN)
    else $error("byte strobe without address strobe");
  AST_STROBE_SEL: assert property (!addressStrobeN |->
    !(upperByteStrobeN && lowerByteStrobeN))
    else $error("cycle without any byte strobe");
  AST_BERR_SEL: assert property ($fell(busErrorOeN) |-> !addressStrobeN)
    else $error("bus error while not selected");
  AST_BERR_NOT_DTACK: assert property (!busErrorOeN |-> dtackOeN)
    else $error("bus error together with acknowledge");
  AST_DATA_ONE_DRIVER: assert property (masterDataOeN || slaveDataOeN)
    else $error("both ends drive the data word");
  AST_WRITE_DATA: assert property (!masterDataOeN |-> !readNotWrite)
    else $error("master drives data in a read");
  AST_RST_HOLD: assert property ($rose(systemResetN) |->
    lowCnt_r >= 10'h18e && lowCnt_r <= 10'h192)
    else $error("system reset pulse length wrong");
endmodule : backplane_sva

/* tb/tb_top.sv */
// testbench: master end and one slave end joined by the backplane wires
// assumes design files and backplane_sva.sv are compiled before it
`timescale 1ns/1ps
module tb_top;
  import backplane_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic powerFailN = 1'b1, timerIrq = 1'b0, serialIrq = 1'b0;
  logic resetInstr = 1'b0, cpuReq = 1'b0, cpuRead = 1'b0;
  xfer_size_type cpuSize = SZ_WORD;
  logic [23:0] cpuAddr = 24'h0, localAddr = 24'h0;
  logic [15:0] cpuWdata = 16'h0, cpuRdata, rdata;
  logic [2:0] ipl;
  logic autovector, cpuDone, cpuBusError, mCoprocN, sCoprocN;
  logic fault = 1'b0, localRead = 1'b0, localWrite = 1'b0;
  logic [7:0] localWdata = 8'h0, localRdata;
  logic slaveIntr, cpuResetN, cpuHaltN, gotDone, gotBerr;
  logic [1:0] busPriority, strobes;
  int num_errors = 0, compares = 0;
  localparam logic [23:0] STATUS_ADDR = 24'h62fffc;
  localparam logic [23:0] CONFIG_ADDR = 24'h62fffe;

  always #12.5 clk = ~clk;

  backplane_if bp_if();
  master_irq_end master_irq_end_inst (.clk(clk), .sys_rst(sys_rst),
    .powerFailN(powerFailN), .timerIrq(timerIrq), .serialIrq(serialIrq),
    .resetInstr(resetInstr), .cpuReq(cpuReq), .cpuRead(cpuRead),
    .cpuSize(cpuSize), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .ipl(ipl),
    .autovector(autovector), .cpuDone(cpuDone), .cpuBusError(cpuBusError),
    .cpuRdata(cpuRdata), .coprocResetN(mCoprocN), .bp(bp_if));
  slave_board_end slave_board_end_inst (.clk(clk), .sys_rst(sys_rst),
    .slot(4'h2), .fault(fault), .localRead(localRead),
    .localWrite(localWrite), .localAddr(localAddr), .localWdata(localWdata),
    .localRdata(localRdata), .slaveIntr(slaveIntr), .cpuResetN(cpuResetN),
    .cpuHaltN(cpuHaltN), .busPriority(busPriority),
    .coprocResetN(sCoprocN), .bp(bp_if));
  backplane_sva backplane_sva_inst (.clk(clk), .sys_rst(sys_rst),
    .addressStrobeN(bp_if.addressStrobeN),
    .upperByteStrobeN(bp_if.upperByteStrobeN),
    .lowerByteStrobeN(bp_if.lowerByteStrobeN),
    .readNotWrite(bp_if.readNotWrite), .masterDataOeN(bp_if.masterDataOeN),
    .slaveDataOeN(bp_if.slaveDataOeN), .irqOeN(bp_if.irqOeN),
    .busErrorOeN(bp_if.busErrorOeN), .dtackOeN(bp_if.dtackOeN),
    .systemResetN(bp_if.systemResetN),
    .reservedFloating(bp_if.reservedFloating));

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout(input string what);
    num_errors++;
    $display("Error at %0t: timeout on %s", $time, what);
    finish_test();
  endtask : timeout

  task automatic wait_release();
    int n;
    n = 0;
    while (bp_if.systemResetN !== 1'b1 && n < 700) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 700) timeout("system reset");
  endtask : wait_release

  // strobes are sampled while the address strobe is low
  task automatic bus_cycle(input logic rd, input xfer_size_type sz,
                           input logic [23:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    strobes = 2'h3;
    @(posedge clk);
    cpuReq <= 1'b1;
    cpuRead <= rd;
    cpuSize <= sz;
    cpuAddr <= a;
    cpuWdata <= wd;
    @(posedge clk);
    cpuReq <= 1'b0;
    #1;
    while (cpuDone !== 1'b1 && cpuBusError !== 1'b1 && n < 1000) begin
      if (bp_if.addressStrobeN === 1'b0) begin
        strobes = {bp_if.upperByteStrobeN, bp_if.lowerByteStrobeN};
      end
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 1000) timeout("bus cycle");
    gotDone = cpuDone;
    gotBerr = cpuBusError;
    rdata = cpuRdata;
    // slave releases acknowledge and master recovers before the next one
    repeat (12) @(posedge clk);
  endtask : bus_cycle

  task automatic raise_req(input logic [15:0] cfg);
    bus_cycle(1'b0, SZ_WORD, CONFIG_ADDR, cfg);
    @(posedge clk);
    localWrite <= 1'b1;
    localAddr <= 24'h4e0006;
    @(posedge clk);
    localWrite <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : raise_req

  task automatic test_reset();
    @(posedge clk);
    #1;
    check(16'(bp_if.systemResetN), 16'h0);
    check(16'({mCoprocN, sCoprocN}), 16'h0);
    wait_release();
    check(16'({cpuResetN, cpuHaltN, busPriority}), 16'hc);
    check(16'(bp_if.backplaneIrqN), 16'h7f);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_levels();
    for (int lvl = 1; lvl <= 4; lvl++) begin
      raise_req(16'hc000 | 16'(lvl << 8));
      check(16'(bp_if.backplaneIrqN), 16'(7'(~(7'h1 << (lvl - 1)))));
      check(16'({autovector, ipl}), 16'(8 + lvl));
      repeat (50) @(posedge clk);
      #1;
      check(16'(ipl), 16'(lvl));
      bus_cycle(1'b1, SZ_WORD, STATUS_ADDR, 16'h0);
      check(16'(rdata[15:8]), 16'h55);
      check(16'({bp_if.backplaneIrqN, ipl}), 16'h3f8);
    end
    $display("test_levels done");
  endtask : test_levels

  task automatic test_onboard();
    logic [15:0] exp [4] = '{16'h7, 16'h6, 16'h4, 16'h3};
    raise_req(16'hc300);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      powerFailN <= (i != 0);
      timerIrq <= (i < 2);
      serialIrq <= (i < 3);
      repeat (6) @(posedge clk);
      #1;
      check(16'(ipl), exp[i]);
    end
    bus_cycle(1'b1, SZ_WORD, STATUS_ADDR, 16'h0);
    $display("test_onboard done");
  endtask : test_onboard

  task automatic test_strobes();
    logic [1:0] exp;
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 2; a++) begin
        bus_cycle(1'b1, xfer_size_type'(s), STATUS_ADDR | 24'(a), 16'h0);
        exp = (a == 1) ? 2'h2 : ((s == 1) ? 2'h1 : 2'h0);
        check(16'(strobes), 16'(exp));
        check(16'({gotDone, rdata[8]}), 16'h3);
      end
    end
    $display("test_strobes done");
  endtask : test_strobes

  task automatic test_berr();
    @(posedge clk);
    fault <= 1'b1;
    bus_cycle(1'b1, SZ_WORD, STATUS_ADDR, 16'h0);
    check(16'({gotBerr, gotDone}), 16'h2);
    @(posedge clk);
    fault <= 1'b0;
    bus_cycle(1'b1, SZ_WORD, STATUS_ADDR, 16'h0);
    check(16'({gotBerr, gotDone}), 16'h1);
    $display("test_berr done");
  endtask : test_berr

  task automatic test_reset_instr();
    raise_req(16'hda00);
    check(16'({busPriority, bp_if.backplaneIrqN}), 16'h1fd);
    @(posedge clk);
    resetInstr <= 1'b1;
    @(posedge clk);
    resetInstr <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(16'({bp_if.systemResetN, mCoprocN, sCoprocN}), 16'h0);
    check(16'(bp_if.backplaneIrqN), 16'h7f);
    wait_release();
    check(16'({busPriority, ipl}), 16'h0);
    bus_cycle(1'b1, SZ_WORD, STATUS_ADDR, 16'h0);
    check(16'({gotDone, rdata[15:8]}), 16'h115);
    $display("test_reset_instr done");
  endtask : test_reset_instr

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset();
    test_levels();
    test_onboard();
    test_strobes();
    test_berr();
    test_reset_instr();
    finish_test();
  end
endmodule : tb_top
